// >>> hw/supervisor_pkg.sv
package supervisor_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int          CLK_PERIOD_NS      = 8;
   localparam int          DEFAULT_FREQ_KHZ   = 500;
   localparam int          DEFAULT_PERIOD_CYC =
      1000000 / (DEFAULT_FREQ_KHZ * CLK_PERIOD_NS);
   localparam int          DESYNC_TIME_US     = 10;
   localparam int          DESYNC_CYC         =
      (DESYNC_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          SOFT_START_PERIODS = 1024;
   localparam int          WD_CAP_PERIODS     = 4096;
   localparam int          CNT_W              = 16;
   localparam int          DUTY_W             = 12;
   localparam logic [CNT_W-1:0] CNT_ZERO      = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE       = 16'h0001;

   // ----------------------------------------------------------------
   // Supervisor states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_OFF       = 3'b000,
      ST_LDO_UP    = 3'b001,
      ST_SOFTSTART = 3'b010,
      ST_RUN       = 3'b011,
      ST_LATCHED   = 3'b100
   } sup_state_type;

   typedef enum logic [1:0] {
      WD_POR  = 2'b00,
      WD_BOOT = 2'b01,
      WD_MON  = 2'b10,
      WD_IDLE = 2'b11
   } wd_state_type;

endpackage : supervisor_pkg

// >>> hw/switch_oscillator.sv
`timescale 1ns/10ps
// Switching oscillator: free-runs, or aligns turn-on to sync rising edges.
module switch_oscillator
   import supervisor_pkg::*;
#(
   parameter int PERIOD_W = 16
) (
   input  wire logic                core_clk,
   input  wire logic                rst,
   input  wire logic                freq_resistor_fitted,
   input  wire logic [PERIOD_W-1:0] frequency_resistor_pin,
   input  wire logic                sync_input,
   output logic                     cycle_start
);
   logic [PERIOD_W-1:0] phase_reg, phase_next;
   logic [PERIOD_W-1:0] quiet_reg, quiet_next;
   logic                sync_d_reg, sync_d_next;
   logic                locked_reg, locked_next;
   logic                start_reg,  start_next;
   logic [PERIOD_W-1:0] period;
   logic                sync_rise;

   // ----------------------------------------------------------------
   // Oscillator
   // ----------------------------------------------------------------
   always_comb begin
      period = freq_resistor_fitted ? frequency_resistor_pin
                                    : PERIOD_W'(DEFAULT_PERIOD_CYC);
      sync_rise   = sync_input & ~sync_d_reg;
      sync_d_next = sync_input;
      quiet_next  = quiet_reg;
      locked_next = locked_reg;
      start_next  = 1'b0;
      phase_next  = phase_reg + 1'b1;
      if (sync_rise) begin
         quiet_next  = '0;
         locked_next = 1'b1;
      end else if (quiet_reg >= PERIOD_W'(DESYNC_CYC)) begin
         locked_next = 1'b0;
      end else begin
         quiet_next = quiet_reg + 1'b1;
      end
      if (locked_reg | sync_rise) begin
         if (sync_rise) begin
            start_next = 1'b1;
            phase_next = '0;
         end
      end else if (phase_reg + 1'b1 >= period) begin
         start_next = 1'b1;
         phase_next = '0;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         phase_reg  <= '0;
         quiet_reg  <= '0;
         sync_d_reg <= 1'b0;
         locked_reg <= 1'b0;
         start_reg  <= 1'b0;
      end else begin
         phase_reg  <= phase_next;
         quiet_reg  <= quiet_next;
         sync_d_reg <= sync_d_next;
         locked_reg <= locked_next;
         start_reg  <= start_next;
      end
   end

   assign cycle_start = start_reg;

   a_desync_unlock: assert property (@(posedge core_clk) disable iff (rst)
      locked_reg && !sync_input && $past(!sync_input) && quiet_reg ==
      PERIOD_W'(DESYNC_CYC) |=> !locked_reg)
      else $error("sync lock not dropped after desync delay");

endmodule : switch_oscillator

// >>> hw/supply_supervisor_watchdog.sv
`timescale 1ns/10ps
module supply_supervisor_watchdog
   import supervisor_pkg::*;
#(
   parameter int SS_PERIODS = SOFT_START_PERIODS,
   parameter int WD_CAP     = WD_CAP_PERIODS
) (
   input  wire logic                            core_clk,
   input  wire logic                            rst,
   input  wire logic                            supply_above_start,
   input  wire logic                            supply_overvoltage,
   input  wire logic                            over_temperature,
   input  wire logic                            enable_high,
   input  wire logic                            gate_drive_above_start,
   input  wire logic                            gate_drive_above_stop,
   input  wire logic                            auxiliary_above_start,
   input  wire logic                            feedback_above_high,
   input  wire logic                            feedback_below_low,
   input  wire logic                            feedback_short,
   input  wire logic                            switch_over_current,
   input  wire logic [DUTY_W-1:0]               error_amp_duty,
   input  wire logic                            freq_resistor_fitted,
   input  wire logic [CNT_W-1:0]                frequency_resistor_pin,
   input  wire logic                            sync_input,
   input  wire logic [CNT_W-1:0]                delay_resistor_pin,
   input  wire logic                            heartbeat_input,
   output logic                                 ldo_on,
   output logic                                 soft_start_active,
   output logic                                 switcher_on,
   output logic                                 power_switch,
   output logic                                 linear_output_status,
   output logic                                 supervisor_reset_out_o,
   output logic                                 supervisor_reset_out_oe_n
);
   import supervisor_pkg::*;

   sup_state_type    st_reg, st_next;
   wd_state_type     wd_reg, wd_next;
   logic [CNT_W-1:0] ss_cnt_reg, ss_cnt_next;
   logic [CNT_W-1:0] dly_cnt_reg, dly_cnt_next;
   logic [DUTY_W-1:0] on_cnt_reg, on_cnt_next;
   logic             sw_reg, sw_next;
   logic             hb_d_reg, hb_d_next;
   logic             rst_low_reg, rst_low_next;
   logic             ldo_reg, ldo_next;
   logic             ss_reg, ss_next;
   logic             smps_reg, smps_next;
   logic             stat_reg, stat_next;
   logic             en_seen_low_reg, en_seen_low_next;
   logic             cycle_start;
   logic             fault;
   logic             hb_fall;
   logic             ss_expired;
   logic [CNT_W-1:0] wd_limit;
   logic [CNT_W-1:0] wd_cap_cnt;

   // ----------------------------------------------------------------
   // Oscillator
   // ----------------------------------------------------------------
   switch_oscillator #(
      .PERIOD_W (CNT_W)
   ) u_osc (
      .core_clk               (core_clk),
      .rst                    (rst),
      .freq_resistor_fitted   (freq_resistor_fitted),
      .frequency_resistor_pin (frequency_resistor_pin),
      .sync_input             (sync_input),
      .cycle_start            (cycle_start)
   );

   // ----------------------------------------------------------------
   // Power sequencing
   // ----------------------------------------------------------------
   assign fault      = ~supply_above_start | supply_overvoltage |
                       over_temperature;
   assign ss_expired = (ss_cnt_reg == CNT_ZERO);

   always_comb begin
      st_next          = st_reg;
      ss_cnt_next      = ss_cnt_reg;
      en_seen_low_next = en_seen_low_reg | ~enable_high;
      ldo_next         = 1'b0;
      ss_next          = 1'b0;
      smps_next        = 1'b0;
      stat_next        = gate_drive_above_stop;
      case (st_reg)
         ST_OFF: begin
            ss_cnt_next = CNT_W'(SS_PERIODS);
            if (supply_above_start && enable_high && !fault) begin
               st_next = ST_LDO_UP;
            end
         end
         ST_LDO_UP: begin
            ldo_next = 1'b1;
            // Enable is checked first so soft-start never starts without it
            if (!enable_high) begin
               st_next = ST_OFF;
            end else if (gate_drive_above_start || auxiliary_above_start) begin
               st_next = ST_SOFTSTART;
            end
         end
         ST_SOFTSTART: begin
            // Enable falling is not acted on here
            ldo_next  = 1'b1;
            ss_next   = 1'b1;
            smps_next = 1'b1;
            if (cycle_start) begin
               ss_cnt_next = ss_cnt_reg - CNT_ONE;
            end
            if (ss_cnt_reg == CNT_ONE && cycle_start) begin
               st_next = ST_RUN;
            end
         end
         ST_RUN: begin
            ldo_next  = 1'b1;
            smps_next = 1'b1;
            if (feedback_short) begin
               st_next          = ST_LATCHED;
               en_seen_low_next = ~enable_high;
            end else if (feedback_below_low && !enable_high) begin
               st_next = ST_OFF;
            end else if (wd_reg == WD_MON && dly_cnt_reg == CNT_ZERO &&
                         !hb_fall && !enable_high) begin
               st_next = ST_OFF;
            end
         end
         ST_LATCHED: begin
            ldo_next = 1'b1;
            if (en_seen_low_reg && enable_high) begin
               st_next = ST_OFF;
            end
         end
         default: begin
            st_next = ST_OFF;
         end
      endcase
      if (fault) begin
         st_next = ST_OFF;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_reg          <= ST_OFF;
         ss_cnt_reg      <= CNT_ZERO;
         en_seen_low_reg <= 1'b0;
         ldo_reg         <= 1'b0;
         ss_reg          <= 1'b0;
         smps_reg        <= 1'b0;
         stat_reg        <= 1'b0;
      end else begin
         st_reg          <= st_next;
         ss_cnt_reg      <= ss_cnt_next;
         en_seen_low_reg <= en_seen_low_next;
         ldo_reg         <= ldo_next;
         ss_reg          <= ss_next;
         smps_reg        <= smps_next;
         stat_reg        <= stat_next;
      end
   end

   // ----------------------------------------------------------------
   // Power switch
   // ----------------------------------------------------------------
   always_comb begin
      sw_next     = sw_reg;
      on_cnt_next = on_cnt_reg;
      if (cycle_start && smps_reg) begin
         sw_next     = 1'b1;
         on_cnt_next = '0;
      end else if (sw_reg) begin
         on_cnt_next = on_cnt_reg + 1'b1;
         if (on_cnt_reg >= error_amp_duty) begin
            sw_next = 1'b0;
         end
      end
      if (switch_over_current || !smps_reg) begin
         sw_next = 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sw_reg     <= 1'b0;
         on_cnt_reg <= '0;
      end else begin
         sw_reg     <= sw_next;
         on_cnt_reg <= on_cnt_next;
      end
   end

   // ----------------------------------------------------------------
   // Watchdog
   // ----------------------------------------------------------------
   // Open delay resistor reads as all ones; the cap limits only the watchdog span, not the reset and boot delays
   assign wd_cap_cnt = CNT_W'(WD_CAP);
   assign wd_limit   = (delay_resistor_pin > wd_cap_cnt) ? wd_cap_cnt
                                                         : delay_resistor_pin;
   assign hb_fall    = hb_d_reg & ~heartbeat_input;

   always_comb begin
      wd_next      = wd_reg;
      dly_cnt_next = dly_cnt_reg;
      hb_d_next    = heartbeat_input;
      rst_low_next = 1'b1;
      if (st_reg != ST_RUN || fault || feedback_below_low) begin
         wd_next      = WD_IDLE;
         dly_cnt_next = delay_resistor_pin;
      end else begin
         case (wd_reg)
            WD_IDLE: begin
               if (feedback_above_high) begin
                  wd_next = WD_POR;
               end
            end
            WD_POR: begin
               // Reset held low for the whole delay
               if (cycle_start) begin
                  dly_cnt_next = dly_cnt_reg - CNT_ONE;
               end
               if (dly_cnt_reg == CNT_ZERO) begin
                  wd_next      = WD_BOOT;
                  dly_cnt_next = delay_resistor_pin;
               end
            end
            WD_BOOT: begin
               rst_low_next = 1'b0;
               if (cycle_start) begin
                  dly_cnt_next = dly_cnt_reg - CNT_ONE;
               end
               if (dly_cnt_reg == CNT_ZERO) begin
                  wd_next      = WD_MON;
                  dly_cnt_next = wd_limit;
               end
            end
            WD_MON: begin
               rst_low_next = 1'b0;
               if (hb_fall) begin
                  dly_cnt_next = wd_limit;
               end else if (dly_cnt_reg == CNT_ZERO) begin
                  wd_next      = WD_POR;
                  rst_low_next = 1'b1;
                  dly_cnt_next = delay_resistor_pin;
               end else if (cycle_start) begin
                  dly_cnt_next = dly_cnt_reg - CNT_ONE;
               end
            end
            default: begin
               wd_next = WD_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wd_reg      <= WD_IDLE;
         dly_cnt_reg <= CNT_ZERO;
         hb_d_reg    <= 1'b0;
         rst_low_reg <= 1'b1;
      end else begin
         wd_reg      <= wd_next;
         dly_cnt_reg <= dly_cnt_next;
         hb_d_reg    <= hb_d_next;
         rst_low_reg <= rst_low_next;
      end
   end

   assign ldo_on                    = ldo_reg;
   assign soft_start_active         = ss_reg;
   assign switcher_on               = smps_reg;
   assign power_switch              = sw_reg;
   assign linear_output_status      = stat_reg;
   assign supervisor_reset_out_o    = 1'b0;
   assign supervisor_reset_out_oe_n = ~rst_low_reg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence s_wd_miss;
      wd_reg == WD_MON && dly_cnt_reg == CNT_ZERO && !hb_fall &&
      st_reg == ST_RUN && !fault && !feedback_below_low;
   endsequence

   a_startup_gate: assert property (@(posedge core_clk) disable iff (rst)
      st_reg == ST_LDO_UP && st_next == ST_SOFTSTART |->
      (gate_drive_above_start || auxiliary_above_start) && enable_high)
      else $error("soft-start entered without start conditions");
   a_status_low: assert property (@(posedge core_clk) disable iff (rst)
      !gate_drive_above_stop |=> !linear_output_status)
      else $error("status not low with gate-drive output under stop");
   a_fb_low_reset: assert property (@(posedge core_clk) disable iff (rst)
      feedback_below_low |=> supervisor_reset_out_oe_n == 1'b0 &&
      wd_reg == WD_IDLE)
      else $error("low feedback did not hold reset");
   a_fb_low_off: assert property (@(posedge core_clk) disable iff (rst)
      st_reg == ST_RUN && feedback_below_low && !enable_high &&
      !feedback_short |=> st_reg == ST_OFF)
      else $error("low feedback with enable low did not shut off");
   a_overcurrent: assert property (@(posedge core_clk) disable iff (rst)
      switch_over_current |=> !power_switch)
      else $error("switch stayed on over current limit");
   a_short_latch: assert property (@(posedge core_clk) disable iff (rst)
      st_reg == ST_RUN && feedback_short && !fault |=>
      st_reg == ST_LATCHED ##1 !switcher_on)
      else $error("short did not latch switcher off");
   a_boot_release: assert property (@(posedge core_clk) disable iff (rst)
      wd_reg == WD_POR && dly_cnt_reg == CNT_ZERO && st_reg == ST_RUN &&
      !fault && !feedback_below_low |=> wd_reg == WD_BOOT ##1
      supervisor_reset_out_oe_n)
      else $error("reset not released at boot delay");
   a_heartbeat_kick: assert property (@(posedge core_clk) disable iff (rst)
      wd_reg == WD_MON && hb_fall && st_reg == ST_RUN && !fault &&
      !feedback_below_low |=> dly_cnt_reg == wd_limit)
      else $error("heartbeat did not restart watchdog delay");
   a_wd_miss: assert property (@(posedge core_clk) disable iff (rst)
      s_wd_miss |=> wd_reg == WD_POR ##1 !supervisor_reset_out_oe_n)
      else $error("missed heartbeat did not pull reset");
   a_wd_cap: assert property (@(posedge core_clk) disable iff (rst)
      wd_reg == WD_BOOT && wd_next == WD_MON |=>
      dly_cnt_reg <= wd_cap_cnt)
      else $error("watchdog delay above cap");
   a_en_ignored: assert property (@(posedge core_clk) disable iff (rst)
      st_reg == ST_SOFTSTART && !enable_high && !fault |=>
      ldo_on && st_reg != ST_OFF)
      else $error("enable low acted on during soft-start");

endmodule : supply_supervisor_watchdog

// >>> verif/heartbeat_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Processor side: heartbeat source, held idle while in reset
// ----------------------------------------------------------------
module heartbeat_model (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        reset_level,
   input  wire logic        beat_enable,
   input  wire logic [15:0] beat_period,
   output logic             heartbeat_input
);
   logic [15:0] cnt_reg;

   // One falling edge per period, period kept below the delay
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cnt_reg         <= 16'h0000;
         heartbeat_input <= 1'b1;
      end else if (!reset_level || !beat_enable) begin
         cnt_reg         <= 16'h0000;
         heartbeat_input <= 1'b1;
      end else begin
         cnt_reg         <= (cnt_reg == beat_period - 16'h0001) ?
                            16'h0000 : cnt_reg + 16'h0001;
         heartbeat_input <= (cnt_reg < (beat_period >> 1));
      end
   end
endmodule : heartbeat_model

// >>> verif/tb_supply_supervisor_watchdog.sv
`timescale 1ns/10ps
module tb_supply_supervisor_watchdog;
   import supervisor_pkg::*;
   logic core_clk, rst, sup, ovv, otp, en, gds, gdp, aux, fbh, fbl, fbs;
   logic ocur, frf, sync, hb, beat_en;
   logic [DUTY_W-1:0] duty;
   logic [CNT_W-1:0]  fpin, dpin;
   logic ldo_on, ss_act, sw_on, pwr_sw, lstat, rst_o, rst_oe_n, rst_pin;
   int   n_mismatch, comparisons, n, i;
   // Rows: supply, enable, gd start, gd stop, aux start | switcher, status
   logic [6:0] rows [6] = '{7'b11111_11, 7'b01111_01, 7'b10111_01,
                            7'b11000_00, 7'b11011_11, 7'b11101_10};

   assign rst_pin = rst_oe_n ? 1'b1 : rst_o; // pull-up on the reset line

   supply_supervisor_watchdog #(.SS_PERIODS(4), .WD_CAP(8)) u_dut (
      .core_clk(core_clk), .rst(rst), .supply_above_start(sup),
      .supply_overvoltage(ovv), .over_temperature(otp), .enable_high(en),
      .gate_drive_above_start(gds), .gate_drive_above_stop(gdp),
      .auxiliary_above_start(aux), .feedback_above_high(fbh),
      .feedback_below_low(fbl), .feedback_short(fbs),
      .switch_over_current(ocur), .error_amp_duty(duty),
      .freq_resistor_fitted(frf), .frequency_resistor_pin(fpin),
      .sync_input(sync), .delay_resistor_pin(dpin), .heartbeat_input(hb),
      .ldo_on(ldo_on), .soft_start_active(ss_act), .switcher_on(sw_on),
      .power_switch(pwr_sw), .linear_output_status(lstat),
      .supervisor_reset_out_o(rst_o),
      .supervisor_reset_out_oe_n(rst_oe_n));

   heartbeat_model u_cpu (.core_clk(core_clk), .rst(rst),
      .reset_level(rst_pin), .beat_enable(beat_en),
      .beat_period(16'h001E), .heartbeat_input(hb));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task check(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task finish_test;
      $display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : finish_test

   task do_reset;
      rst <= 1'b1;
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      @(negedge core_clk);
   endtask : do_reset

   // Waits on the reset line enable; a miss shows up as a wrong level
   task wait_oe(input logic v, input int lim);
      n = 0;
      while (rst_oe_n !== v && n < lim) begin
         @(negedge core_clk);
         n++;
      end
   endtask : wait_oe

   task bring_up;
      @(posedge core_clk);
      {sup, en, gds, gdp, aux, fbh, fbl} <= 7'b1111110;
      repeat (5) @(negedge core_clk);
   endtask : bring_up

   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   initial begin
      repeat (60000) @(posedge core_clk);
      n_mismatch++;
      finish_test();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      {rst, sup, ovv, otp, en, gds, gdp, aux, fbh, fbl, fbs} = 11'h400;
      {ocur, sync, beat_en} = 3'b000;
      frf = 1'b1;
      fpin = 16'h0014;
      dpin = 16'h0003;
      duty = 12'h00A;
      n_mismatch = 0;
      comparisons = 0;
      repeat (12) @(posedge core_clk);
      @(negedge core_clk);
      check({ldo_on, sw_on, pwr_sw, lstat, rst_oe_n}, 16'h0000);
      for (i = 0; i < 6; i++) begin
         do_reset();
         @(posedge core_clk);
         {sup, en, gds, gdp, aux} <= rows[i][6:2];
         repeat (30) @(negedge core_clk);
         check(sw_on, rows[i][1]);
         check(lstat, rows[i][0]);
      end
      $display("test start gating done");

      do_reset();
      beat_en <= 1'b1;
      bring_up();
      wait_oe(1'b1, 400);
      check(rst_oe_n, 1'b1);
      check(n > 40, 1'b1);
      repeat (500) @(negedge core_clk);
      check(rst_oe_n, 1'b1);
      beat_en <= 1'b0;
      wait_oe(1'b0, 200);
      check({rst_oe_n, sw_on, ldo_on}, 16'h0003);
      beat_en <= 1'b1;
      wait_oe(1'b1, 400);
      check(rst_oe_n, 1'b1);
      $display("test heartbeat done");

      @(posedge core_clk);
      fbl <= 1'b1;
      repeat (3) @(negedge core_clk);
      check(rst_oe_n, 1'b0);
      fbl <= 1'b0;
      wait_oe(1'b1, 400);
      check(rst_oe_n, 1'b1);
      @(posedge core_clk);
      ocur <= 1'b1;
      repeat (2) @(negedge core_clk);
      for (i = 0; i < 60; i++) begin
         @(negedge core_clk);
         check(pwr_sw, 1'b0);
      end
      ocur <= 1'b0;
      $display("test monitor and current limit done");

      // Sync: turn-on lands two edges after each rising sync edge
      for (i = 0; i < 4; i++) begin
         @(posedge core_clk);
         sync <= 1'b1;
         repeat (2) @(negedge core_clk);
         if (i > 0) check(pwr_sw, 1'b0);
         @(negedge core_clk);
         check(pwr_sw, 1'b1);
         repeat (6) @(posedge core_clk);
         sync <= 1'b0;
         repeat (8) @(posedge core_clk);
      end
      repeat (1300) @(negedge core_clk);
      n = 0;
      while (pwr_sw !== 1'b1 && n < 60) begin
         @(negedge core_clk);
         n++;
      end
      check(pwr_sw, 1'b1);
      $display("test sync done");

      @(posedge core_clk);
      fbs <= 1'b1;
      repeat (5) @(negedge core_clk);
      fbs <= 1'b0;
      repeat (100) @(negedge core_clk);
      check(sw_on, 1'b0);
      en <= 1'b0;
      repeat (5) @(posedge core_clk);
      en <= 1'b1;
      repeat (150) @(negedge core_clk);
      check(sw_on, 1'b1);
      $display("test short latch done");

      // Delay setting above the cap: watchdog span limited to the cap
      do_reset();
      beat_en <= 1'b0;
      dpin <= 16'h000C;
      bring_up();
      wait_oe(1'b1, 900);
      wait_oe(1'b0, 600);
      check(n >= 360 && n <= 440, 1'b1);
      dpin <= 16'h0003;
      beat_en <= 1'b1;
      wait_oe(1'b1, 400);
      en <= 1'b0;
      beat_en <= 1'b0;
      wait_oe(1'b0, 200);
      repeat (5) @(negedge core_clk);
      check({rst_oe_n, sw_on, ldo_on}, 16'h0000);
      $display("test cap and shut-off done");

      do_reset();
      bring_up();
      repeat (150) @(negedge core_clk);
      @(posedge core_clk);
      {en, fbl} <= 2'b01;
      repeat (30) @(negedge core_clk);
      check({sw_on, ldo_on}, 16'h0000);
      $display("test low feedback shut-off done");
      finish_test();
   end
endmodule : tb_supply_supervisor_watchdog
